// file: src/ercs_top.sv
// range comparators, strobe latches and interval timers of the encoder block
// assumes a binary encoder position and host control bits synchronous to clk
`timescale 1ns/1ps

module ercs_top #(
    parameter int POS_W    = ercs_pkg::POS_W,
    parameter int FAST_CYC = ercs_pkg::FAST_CYC,
    parameter int MS_CYC   = ercs_pkg::MS_CYC
) (
    // clock and reset
    input  wire logic                                       clk,
    input  wire logic                                       sys_rst,
    // encoder position
    input  wire logic [POS_W-1:0]                           pos,
    // comparator configuration
    input  wire logic [ercs_pkg::NUM_CMP-1:0][POS_W-1:0]    cmp_on_preset,
    input  wire logic [ercs_pkg::NUM_CMP-1:0][POS_W-1:0]    cmp_off_preset,
    input  wire logic [ercs_pkg::HW_CMP-1:0]                cmp_timer_mode,
    input  wire logic [ercs_pkg::HW_CMP-1:0][15:0]          first_pulse_duration,
    input  wire logic [ercs_pkg::HW_CMP-1:0][15:0]          second_pulse_duration,
    // host control
    input  wire logic [ercs_pkg::HW_CMP-1:0]                out_enable,
    input  wire logic                                       host_stopped,
    input  wire ercs_pkg::ercs_stop_t                       stop_policy,
    // shared terminals 9-12
    input  wire logic [ercs_pkg::NUM_STB-1:0]               term_in,
    input  wire logic [ercs_pkg::NUM_STB-1:0]               term_is_out,
    output logic      [ercs_pkg::NUM_STB-1:0]               term_out,
    output logic      [ercs_pkg::NUM_STB-1:0]               term_oe,
    // strobe and timer configuration
    input  wire logic [ercs_pkg::NUM_STB-1:0]               stb_edge_rise,
    input  wire logic [ercs_pkg::NUM_STB-1:0]               stb_gate_en,
    input  wire logic [ercs_pkg::NUM_STB-1:0]               stb_rearm,
    input  wire logic [ercs_pkg::NUM_TMR-1:0]               tmr_dual,
    // dedicated outputs 1-4
    output logic      [3:0]                                 hw_out,
    // returned status
    output logic      [15:0]                                cmp_status,
    output logic      [15:0]                                cmp_word,
    output logic      [ercs_pkg::NUM_STB-1:0]               input_level,
    output logic      [ercs_pkg::NUM_STB-1:0]               stb_flag,
    output logic      [ercs_pkg::NUM_STB-1:0][POS_W-1:0]    stb_value,
    output logic      [ercs_pkg::NUM_TMR-1:0][15:0]         tmr_value
);

    localparam int HW = ercs_pkg::HW_CMP;
    localparam int FW = $clog2(FAST_CYC);
    localparam int MW = $clog2(MS_CYC);
    localparam int SW = $clog2(ercs_pkg::SLOW_DIV);
    localparam int DW = ercs_pkg::DUR_W;
    localparam int TW = ercs_pkg::TMR_W;

    typedef struct packed {
        logic [FW-1:0]                 fast_cnt;
        logic [MW-1:0]                 ms_cnt;
        logic [SW-1:0]                 slow_cnt;
        logic [POS_W-1:0]              pos_prev;
        logic [HW-1:0]                 raw;
        logic [HW-1:0]                 hold;
        logic [HW-1:0]                 hw;
        logic [HW-1:0]                 pin;
        logic [3:0]                    oe;
        logic [3:0]                    lvl;
        logic [HW-1:0][DW-1:0]         remain;
        logic [ercs_pkg::MID_CMP-1:0]  mid;
        logic [ercs_pkg::WORD_CMP-1:0] word;
        logic [ercs_pkg::NUM_TMR-1:0]  run;
        logic [ercs_pkg::NUM_TMR-1:0][TW-1:0] tval;
    } ercs_state_t;

    ercs_state_t                    s_q;
    ercs_state_t                    s_d;
    logic                           fast_tick;
    logic                           slow_tick;
    logic                           ms_tick;
    logic [HW-1:0]                  on_hit;
    logic [HW-1:0]                  off_hit;
    logic [ercs_pkg::NUM_STB-1:0]   cfg_edge;
    logic [ercs_pkg::NUM_STB-1:0]   opp_edge;
    logic [ercs_pkg::NUM_TMR-1:0]   tmr_start;
    logic [ercs_pkg::NUM_TMR-1:0]   tmr_stop;

    ////////////////////////////////////////////////////////////////////////////
    // preset window test shared by every comparator
    function automatic logic ercs_window(input logic [POS_W-1:0] p,
                                         input logic [POS_W-1:0] on_p,
                                         input logic [POS_W-1:0] off_p);
        if (off_p > on_p)
        begin
            ercs_window = (p >= on_p) && (p <= off_p);
        end
        else if (off_p < on_p)
        begin
            ercs_window = !((p >= off_p) && (p <= on_p));
        end
        else
        begin
            ercs_window = (p == on_p);
        end
    endfunction : ercs_window

    ////////////////////////////////////////////////////////////////////////////
    // update ticks: 500 us fast, every eighth fast tick slow, 1 ms timebase
    assign fast_tick = (s_q.fast_cnt == FW'(FAST_CYC - 1));
    assign slow_tick = fast_tick && (s_q.slow_cnt == SW'(ercs_pkg::SLOW_DIV - 1));
    assign ms_tick   = (s_q.ms_cnt == MW'(MS_CYC - 1));

    // strobe channels for shared terminals 9-12
    for (genvar i = 0; i < ercs_pkg::NUM_STB; i++)
    begin : g_stb
        ercs_strobe #(
            .POS_W     (POS_W)
        ) u_stb (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .lvl       (term_in[i]),
            .active    (!term_is_out[i]),
            .edge_rise (stb_edge_rise[i]),
            .latch_en  (!stb_gate_en[i] || s_q.raw[ercs_pkg::STB_OFS + i]),
            .rearm     (stb_rearm[i]),
            .pos       (pos),
            .flag      (stb_flag[i]),
            .value     (stb_value[i]),
            .cfg_edge  (cfg_edge[i]),
            .opp_edge  (opp_edge[i])
        );
    end

    // interval timer events, same edges as the strobe latches
    always_comb
    begin
        for (int j = 0; j < ercs_pkg::NUM_TMR; j++)
        begin
            tmr_start[j] = cfg_edge[2*j+1];
            tmr_stop[j]  = tmr_dual[j] ? cfg_edge[2*j] : opp_edge[2*j+1];
        end
    end

    // preset crossings seen between two fast samples; skipped counts miss a hit
    always_comb
    begin
        for (int k = 0; k < HW; k++)
        begin
            on_hit[k]  = fast_tick && (pos == cmp_on_preset[k]) && (s_q.pos_prev != cmp_on_preset[k]);
            off_hit[k] = fast_tick && (pos == cmp_off_preset[k]) && (s_q.pos_prev != cmp_off_preset[k]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        s_d          = s_q;
        s_d.fast_cnt = fast_tick ? '0 : s_q.fast_cnt + 1'b1;
        s_d.ms_cnt   = ms_tick ? '0 : s_q.ms_cnt + 1'b1;
        s_d.lvl      = term_in;
        s_d.oe       = term_is_out;
        if (fast_tick)
        begin
            s_d.slow_cnt = slow_tick ? '0 : s_q.slow_cnt + 1'b1;
            s_d.pos_prev = pos;
        end
        // pulse timers of comparators 1-8; a zero duration loads zero, so no pulse runs
        for (int k = 0; k < HW; k++)
        begin
            if (on_hit[k])
            begin
                s_d.remain[k] = first_pulse_duration[k];
            end
            else if (off_hit[k])
            begin
                s_d.remain[k] = second_pulse_duration[k];
            end
            else if (ms_tick && s_q.remain[k] != '0)
            begin
                s_d.remain[k] = s_q.remain[k] - 1'b1;
            end
        end
        // comparators 1-8 and their pins, sampled on the fast tick
        if (fast_tick)
        begin
            for (int k = 0; k < HW; k++)
            begin
                s_d.raw[k] = cmp_timer_mode[k] ? (s_d.remain[k] != '0)
                                               : ercs_window(pos, cmp_on_preset[k], cmp_off_preset[k]);
            end
            if (!host_stopped || stop_policy == ercs_pkg::ERCS_STOP_NORMAL)
            begin
                s_d.hw = s_d.raw;
            end
            else if (stop_policy == ercs_pkg::ERCS_STOP_FORCE_OFF)
            begin
                s_d.hw = '0;
            end
            else
            begin
                s_d.hw = s_q.hold;
            end
        end
        // last pin state before the stop, frozen while stopped
        s_d.hold = host_stopped ? s_q.hold : s_q.hw;
        // enable gates only the pin; status keeps the raw result
        s_d.pin = s_q.hw & out_enable & {term_is_out, 4'hF};
        // comparators 9-32 on the slow tick
        if (slow_tick)
        begin
            for (int k = 0; k < ercs_pkg::MID_CMP; k++)
            begin
                s_d.mid[k] = ercs_window(pos, cmp_on_preset[HW+k], cmp_off_preset[HW+k]);
            end
            for (int k = 0; k < ercs_pkg::WORD_CMP; k++)
            begin
                s_d.word[k] = ercs_window(pos, cmp_on_preset[HW+ercs_pkg::MID_CMP+k],
                                          cmp_off_preset[HW+ercs_pkg::MID_CMP+k]);
            end
        end
        // interval timers, counting whole milliseconds
        for (int j = 0; j < ercs_pkg::NUM_TMR; j++)
        begin
            if (tmr_start[j])
            begin
                s_d.run[j]  = 1'b1;
                s_d.tval[j] = '0;
            end
            else if (tmr_stop[j])
            begin
                s_d.run[j] = 1'b0;
            end
            else if (s_q.run[j] && ms_tick && s_q.tval[j] != ercs_pkg::TMR_SAT)
            begin
                s_d.tval[j] = s_q.tval[j] + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign hw_out      = s_q.pin[3:0];
    assign term_out    = s_q.pin[7:4];
    assign term_oe     = s_q.oe;
    assign cmp_status  = {s_q.mid, s_q.raw};
    assign cmp_word    = s_q.word;
    assign input_level = s_q.lvl;
    assign tmr_value   = s_q.tval;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_PIN_ENABLE: assert property ((hw_out & ~$past(out_enable[3:0])) == 4'h0)
        else $error("pin driven without output enable");
    AST_PIN_ON_TICK: assert property ((s_q.hw != $past(s_q.hw)) |-> $past(fast_tick))
        else $error("comparator pin changed between fast ticks");
    AST_PRESET_INSIDE: assert property ((fast_tick && !cmp_timer_mode[0]
            && cmp_off_preset[0] > cmp_on_preset[0] && pos >= cmp_on_preset[0]
            && pos <= cmp_off_preset[0]) |=> s_q.raw[0])
        else $error("inside window but comparator off");
    AST_PRESET_OUTSIDE: assert property ((fast_tick && !cmp_timer_mode[1]
            && cmp_off_preset[1] < cmp_on_preset[1] && pos >= cmp_off_preset[1]
            && pos <= cmp_on_preset[1]) |=> !s_q.raw[1])
        else $error("inside inverted window but comparator on");
    AST_PRESET_EQUAL: assert property ((fast_tick && !cmp_timer_mode[2] && cmp_off_preset[2] == cmp_on_preset[2])
            |=> s_q.raw[2] == ($past(pos) == $past(cmp_on_preset[2])))
        else $error("equal preset comparison wrong");
    AST_PULSE_LOAD: assert property ((on_hit[0] && first_pulse_duration[0] != 16'h0000)
            |=> s_q.remain[0] == $past(first_pulse_duration[0]))
        else $error("pulse not loaded at on preset");
    AST_ZERO_PULSE: assert property ((on_hit[0] && first_pulse_duration[0] == 16'h0000)
            |=> s_q.remain[0] == 16'h0000)
        else $error("zero duration still produced a pulse");
    AST_FORCE_OFF: assert property ((fast_tick && host_stopped && stop_policy == ercs_pkg::ERCS_STOP_FORCE_OFF)
            |=> s_q.hw == 8'h00 ##1 hw_out == 4'h0)
        else $error("force off policy left a pin on");
    AST_HOLD_FROZEN: assert property ($past(host_stopped) |-> s_q.hold == $past(s_q.hold))
        else $error("held pin state changed while stopped");
    AST_SLOW_BITS: assert property ((s_q.mid != $past(s_q.mid)) |-> $past(slow_tick))
        else $error("comparators 9-16 changed off the slow tick");
    AST_SLOW_WORD: assert property ((s_q.word != $past(s_q.word)) |-> $past(slow_tick))
        else $error("comparator word changed off the slow tick");
    AST_TMR_START: assert property (tmr_start[0] |=> s_q.run[0] && tmr_value[0] == 16'h0000)
        else $error("timer did not restart from zero");
    AST_TMR_DUAL_STOP: assert property ((tmr_dual[0] && cfg_edge[0] && !tmr_start[0]) |=> !s_q.run[0])
        else $error("dual mode stop edge ignored");
    AST_TMR_SAT: assert property (($past(s_q.tval[0]) == ercs_pkg::TMR_SAT && !$past(tmr_start[0]))
            |-> tmr_value[0] == ercs_pkg::TMR_SAT)
        else $error("interval count wrapped");

endmodule : ercs_top

// file: src/ercs_pkg.sv
// constants, types and timing counts for the encoder range comparator and strobe block
// assumes one 250 MHz clock and an encoder position already decoded to binary
//
// Operation
// - each shared terminal 9-12 is either an input or one of outputs 5-8, by configuration
// - 32 comparators: 1-8 bits and pins, 9-16 bits only, 17-32 one word
// - comparators 1-8 refresh their pins every 500 us from presets and two timers
// - a comparator pin is active only while its host output enable is set
// - comparator status bits update even when no pin is configured for them
// - preset mode, off above on: output on between on and off inclusive
// - preset mode, off below on: output off between off and on inclusive
// - preset mode, equal presets: output on only at that exact position
// - timer mode: pulse at on preset for first duration, at off for second
// - a zero pulse duration suppresses that pulse, leaving one pulse per turn
// - host stopped: pins follow stop policy normal, force off or hold last
// - comparators 9-16 use on/off presets, recomputed every 4 ms
// - comparators 17-32 recomputed every 4 ms and packed into one word
// - current level of each shared input is reported as its own bit
// - configured strobe edge captures position and sets the strobe flag
// - while the flag is set and no rearm is given, later edges leave the captured value alone
// - optionally comparators 5-8 act as extra enables for strobe latches 9-12
// - two interval timers, inputs 9/10 and 11/12, each reported as one word
// - single mode: configured edge of second input starts, opposite edge stops, 1 ms
// - dual mode: second input starts, first input stops, each on its configured edge
// - timers use the same edge selected for each input's strobe latch
package ercs_pkg;

    // sizes
    localparam int NUM_CMP  = 32;
    localparam int HW_CMP   = 8;
    localparam int MID_CMP  = 8;
    localparam int WORD_CMP = 16;
    localparam int NUM_STB  = 4;
    localparam int NUM_TMR  = 2;
    localparam int POS_W    = 16;
    localparam int DUR_W    = 16;
    localparam int TMR_W    = 16;
    localparam int STB_OFS  = 4;

    // timing, each in its own unit
    localparam int CLK_PERIOD_PS = 4000;
    localparam int FAST_TICK_US  = 500;
    localparam int SLOW_TICK_MS  = 4;
    localparam int RES_MS        = 1;

    // derived cycle counts
    localparam int FAST_CYC = FAST_TICK_US * 1000 * 1000 / CLK_PERIOD_PS;
    localparam int MS_CYC   = RES_MS * 1000 * 1000 * 1000 / CLK_PERIOD_PS;
    localparam int SLOW_DIV = SLOW_TICK_MS * 1000 / FAST_TICK_US;

    // saturation value of an interval count
    localparam logic [TMR_W-1:0] TMR_SAT = 16'hFFFF;

    // pin policy while the host is stopped
    typedef enum logic [1:0] {
        ERCS_STOP_NORMAL,
        ERCS_STOP_FORCE_OFF,
        ERCS_STOP_HOLD_LAST
    } ercs_stop_t;

endpackage : ercs_pkg

// file: src/ercs_strobe.sv
// one strobe latch channel: edge detect, position capture and flag
// assumes the input level is synchronous to clk
`timescale 1ns/1ps

module ercs_strobe #(
    parameter int POS_W = ercs_pkg::POS_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // pin and configuration
    input  wire logic             lvl,
    input  wire logic             active,
    input  wire logic             edge_rise,
    input  wire logic             latch_en,
    input  wire logic             rearm,
    input  wire logic [POS_W-1:0] pos,
    // results
    output logic                  flag,
    output logic [POS_W-1:0]      value,
    output logic                  cfg_edge,
    output logic                  opp_edge
);

    typedef struct packed {
        logic             prev;
        logic             flag;
        logic [POS_W-1:0] value;
    } ercs_stb_t;

    ercs_stb_t s_q;
    ercs_stb_t s_d;
    logic      capture;

    ////////////////////////////////////////////////////////////////////////////
    // edge detect and capture; a capture in the rearm cycle wins over the clear
    always_comb
    begin
        cfg_edge = active & (edge_rise ? (lvl & ~s_q.prev) : (~lvl & s_q.prev));
        opp_edge = active & (edge_rise ? (~lvl & s_q.prev) : (lvl & ~s_q.prev));
        capture  = cfg_edge & latch_en & (~s_q.flag | rearm);
        s_d      = s_q;
        s_d.prev = lvl;
        s_d.flag = capture | (s_q.flag & ~rearm);
        if (capture)
        begin
            s_d.value = pos;
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign flag  = s_q.flag;
    assign value = s_q.value;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_CAPTURE: assert property (capture |=> flag && value == $past(pos))
        else $error("strobe edge did not capture position");
    AST_NO_OVERWRITE: assert property ((flag && !rearm) |=> $stable(value))
        else $error("captured value changed while flag set");
    AST_REARM: assert property ((flag && rearm && !cfg_edge) |=> !flag)
        else $error("rearm did not clear strobe flag");

endmodule : ercs_strobe

// file: test/ercs_host_model.sv
// host side model: rearms each strobe latch after it has seen the flag
// assumes the flags and clock of the block under test
`timescale 1ns/1ps

module ercs_host_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // strobe handshake
    input  wire logic [3:0] stb_flag,
    input  wire logic [3:0] ack_en,
    input  wire logic       slow,
    output logic      [3:0] stb_rearm
);
    int unsigned wait_q [4];

    // a slow host lets the flag stand several scans before rearming
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (sys_rst || !stb_flag[i] || !ack_en[i])
            begin
                wait_q[i]    <= 0;
                stb_rearm[i] <= 1'b0;
            end
            else if (wait_q[i] >= (slow ? 6 : 1))
            begin
                stb_rearm[i] <= 1'b1;
            end
            else
            begin
                wait_q[i] <= wait_q[i] + 1;
            end
        end
    end
endmodule : ercs_host_model

// file: test/tb_encoder_range_comparator_strobe.sv
// bench for the comparator, strobe and interval timer block
// assumes shortened tick counts and a host model on the strobe flags
`timescale 1ns/1ps

module tb_encoder_range_comparator_strobe;
    logic                 clk, sys_rst, host_stopped, slow;
    logic [15:0]          pos, cmp_status, cmp_word;
    logic [31:0][15:0]    on_p, off_p;
    logic [7:0]           tmode, oen;
    logic [7:0][15:0]     dur1, dur2;
    logic [3:0]           term_in, term_is_out, term_out, term_oe, edge_r, gate;
    logic [3:0]           ack, rearm, hw_out, in_lvl, flag;
    logic [3:0][15:0]     sval;
    logic [1:0][15:0]     tval;
    logic [1:0]           dual;
    logic [31:0]          ge;
    ercs_pkg::ercs_stop_t pol;
    int                   n_fail, checks_done;
    int                   seed = 32'h165C;
    int                   pl [5] = '{79, 80, 90, 106, 107};

    ercs_top #(.FAST_CYC(40), .MS_CYC(20)) i_ercs_top (
        .clk(clk), .sys_rst(sys_rst), .pos(pos),
        .cmp_on_preset(on_p), .cmp_off_preset(off_p), .cmp_timer_mode(tmode),
        .first_pulse_duration(dur1), .second_pulse_duration(dur2),
        .out_enable(oen), .host_stopped(host_stopped), .stop_policy(pol),
        .term_in(term_in), .term_is_out(term_is_out), .term_out(term_out), .term_oe(term_oe),
        .stb_edge_rise(edge_r), .stb_gate_en(gate), .stb_rearm(rearm), .tmr_dual(dual),
        .hw_out(hw_out), .cmp_status(cmp_status), .cmp_word(cmp_word), .input_level(in_lvl),
        .stb_flag(flag), .stb_value(sval), .tmr_value(tval));

    ercs_host_model i_ercs_host_model (
        .clk(clk), .sys_rst(sys_rst), .stb_flag(flag), .ack_en(ack), .slow(slow), .stb_rearm(rearm));

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog; the watchdog allows well over the expected run
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        #40000;
        n_fail++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////
    // reference model and helpers
    function automatic logic cmp_f(input int p, input int on, input int off);
        if (off > on) return p >= on && p <= off;
        if (off < on) return !(p >= off && p <= on);
        return p == on;
    endfunction : cmp_f

    function automatic logic [31:0] model_f(input int p);
        logic [31:0] r;
        for (int i = 0; i < 32; i++) r[i] = cmp_f(p, int'(on_p[i]), int'(off_p[i]));
        return r;
    endfunction : model_f

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // hold a position past a full slow tick so every group has sampled it
    task automatic t_preset(input int p);
        logic [31:0] e;
        pos = p[15:0];
        cyc(340);
        e = model_f(p);
        chk(cmp_status, e[15:0]);
        chk(cmp_word, e[31:16]);
        chk(hw_out, e[3:0] & oen[3:0]);
        chk(term_out, e[7:4] & oen[7:4] & term_is_out);
        chk(term_oe, term_is_out);
    endtask : t_preset

    // comparator 1 on at 90, off at 200, while the host goes to stop
    task automatic t_stop(input int k, input logic a, input logic b);
        pol = ercs_pkg::ercs_stop_t'(k);
        pos = 16'h005A;
        cyc(340);
        host_stopped = 1'b1;
        pos = 16'h00C8;
        cyc(340);
        chk(hw_out[0], a);
        pos = 16'h005A;
        cyc(340);
        chk(hw_out[0], b);
        host_stopped = 1'b0;
    endtask : t_stop

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        for (int i = 0; i < 32; i++) on_p[i] = 16'($random(seed));
        for (int i = 0; i < 32; i++) off_p[i] = 16'($random(seed));
        on_p[0] = 16'h0050;
        off_p[0] = 16'h006A;
        on_p[1] = 16'h006A;
        off_p[1] = 16'h0050;
        on_p[2] = 16'h005A;
        off_p[2] = 16'h005A;
        oen = 8'($random(seed));
        {tmode, dur1, dur2, host_stopped, pos, term_in, gate, ack, dual} = '0;
        pol = ercs_pkg::ERCS_STOP_NORMAL;
        term_is_out = 4'h3;
        edge_r = 4'hF;
        slow = 1'b1;
        sys_rst = 1'b1;
        cyc(8);
        sys_rst = 1'b0;
        for (int i = 0; i < 5; i++) t_preset(pl[i]);
        t_preset($random(seed) & 32'h0000FFFF);
        // timer mode: six ms pulse at the on point, none at the off point
        tmode = 8'h01;
        dur1[0] = 16'h0006;
        on_p[0] = 16'h00C8;
        off_p[0] = 16'h012C;
        pos = 16'h0010;
        cyc(100);
        pos = 16'h00C8;
        cyc(60);
        chk(cmp_status[0], 1'b1);
        cyc(200);
        chk(cmp_status[0], 1'b0);
        pos = 16'h012C;
        cyc(60);
        chk(cmp_status[0], 1'b0);
        tmode = 8'h00;
        on_p[0] = 16'h0050;
        off_p[0] = 16'h006A;
        oen = 8'hFF;
        t_stop(0, 1'b0, 1'b1);
        t_stop(1, 1'b0, 1'b0);
        t_stop(2, 1'b1, 1'b1);
        // strobe capture, lockout and rearm by a slow host
        term_is_out = 4'h0;
        pos = 16'h1234;
        term_in = 4'hF;
        cyc(1);
        chk(flag, 4'hF);
        chk(sval, {4{16'h1234}});
        chk(in_lvl, 4'hF);
        pos = 16'h4321;
        term_in = 4'h0;
        cyc(2);
        term_in = 4'hF;
        cyc(2);
        chk(sval, {4{16'h1234}});
        ack = 4'hF;
        cyc(12);
        ack = 4'h0;
        chk(flag, 4'h0);
        // gated strobes follow comparators 5-8, prompt host
        cyc(340);
        ge = model_f(32'h00004321);
        gate = 4'hF;
        slow = 1'b0;
        term_in = 4'h0;
        cyc(2);
        term_in = 4'hF;
        cyc(1);
        chk(flag, ge[7:4]);
        ack = 4'hF;
        cyc(6);
        ack = 4'h0;
        // timer 0 dual, falling 10 then rising 9; timer 1 single, rising then falling 12
        dual = 2'b01;
        edge_r = 4'b1101;
        cyc(1);
        term_in = 4'h0;
        cyc(2);
        term_in = 4'h8;
        cyc(60);
        term_in = 4'h0;
        cyc(40);
        term_in = 4'h1;
        cyc(3);
        chk(tval[0] >= 16'h0004 && tval[0] <= 16'h0006, 1'b1);
        chk(tval[1] >= 16'h0002 && tval[1] <= 16'h0004, 1'b1);
        final_report();
    end
endmodule : tb_encoder_range_comparator_strobe
